// ===== rtl/phy_crossover_cable_irq_regs.sv
// Per-port PHY register bank: crossover mode, cable length, event flags.
// Assumes a single-cycle register port with read data one cycle later.
//
// Overview of operation
// - Register bits pick straight, cross or auto.
// - Auto strap wins; manual strap picks wiring.
// - Cable length in bits 15:12, resets zero.
// - Length valid only at 100 Mb/s, clean cable.
// - No length reported for 10 Mb/s links.
// - Flags read-only, latch high until cleared.
// - Reading flags returns them, then clears all but events set in the read cycle.
// - Each flag gated by same-position mask bit.
// - Bit 9 sets on link up.
// - Bit 8 sets on wake event.
// - Bit 7 sets on energy detected rising.
// - Bit 6 sets on negotiation complete.
// - Bit 5 sets on remote fault.
// - Bit 4 sets on link down.
// - Bit 3 sets on partner acknowledge.
// - Bit 2 sets on parallel detection fault.
// - Bit 1 sets on page received.
// - Register bits rule only when override set.
// - Mask 0 suppresses, mask 1 enables source.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module phy_crossover_cable_irq_regs (
  // Clock and control
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  // Register port
  input  wire phy_mgmt_pkg::reg_req_t    req,
  output logic                    [15:0] rdata,
  // Straps
  input  wire logic                      auto_xover_strap,
  input  wire logic                      manual_xover_strap,
  // PHY status
  input  wire phy_mgmt_pkg::phy_status_t phy_stat,
  // Results
  output phy_mgmt_pkg::xover_mode_t      xover_mode,
  output logic                    [15:0] event_flags
);
  import phy_mgmt_pkg::*;

  // --------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------
  logic wr_ctrl;
  logic wr_cable;
  logic wr_mask;
  logic rd_flags;
  assign wr_ctrl  = req.wr && (req.addr == IDX_MODE_CTRL_STAT);
  assign wr_cable = req.wr && (req.addr == IDX_CABLE_LEN);
  assign wr_mask  = req.wr && (req.addr == IDX_EVENT_MASK);
  assign rd_flags = req.rd && (req.addr == IDX_EVENT_FLAGS);

  // --------------------------------------------------------------------
  // Crossover control
  // --------------------------------------------------------------------
  logic [2:0] xo_ctrl_r;
  logic [2:0] xo_ctrl_nxt;
  logic       xo_override;
  logic       xo_auto;
  logic       xo_state;
  assign xo_ctrl_nxt = wr_ctrl ? {req.wdata[XO_OVERRIDE_BIT], req.wdata[XO_AUTO_BIT],
                                  req.wdata[XO_STATE_BIT]} : xo_ctrl_r;
  assign xo_override = xo_ctrl_r[2];
  assign xo_auto     = xo_ctrl_r[1];
  assign xo_state    = xo_ctrl_r[0];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      xo_ctrl_r <= CTRL_RESET;
    end else if (ce) begin
      xo_ctrl_r <= xo_ctrl_nxt;
    end
  end

  // The reserved combination of both bits set falls back to auto detection.
  xover_mode_t reg_mode;
  xover_mode_t strap_mode;
  xover_mode_t mode_nxt;
  xover_mode_t mode_r;
  always_comb begin
    case ({xo_auto, xo_state})
      2'b00:   reg_mode = XO_STRAIGHT;
      2'b01:   reg_mode = XO_CROSS;
      2'b10:   reg_mode = XO_AUTO;
      default: reg_mode = XO_AUTO;
    endcase
  end
  assign strap_mode = auto_xover_strap ? XO_AUTO :
                      (manual_xover_strap ? XO_CROSS : XO_STRAIGHT);
  assign mode_nxt   = xo_override ? reg_mode : strap_mode;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode_r <= XO_STRAIGHT;
    end else if (ce) begin
      mode_r <= mode_nxt;
    end
  end
  assign xover_mode = mode_r;

  // --------------------------------------------------------------------
  // Cable length estimate
  // --------------------------------------------------------------------
  // The low twelve bits keep what software wrote; they carry no function.
  logic [3:0]  cable_r;
  logic [3:0]  cable_nxt;
  logic [11:0] cable_low_r;
  logic [11:0] cable_low_nxt;
  logic        cable_valid;
  assign cable_valid   = phy_stat.link_up && phy_stat.speed_100 &&
                         !phy_stat.cable_fault;
  assign cable_nxt     = cable_valid ? phy_stat.cable_len : CBL_RESET;
  assign cable_low_nxt = wr_cable ? req.wdata[11:0] : cable_low_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cable_r     <= CBL_RESET;
      cable_low_r <= CBL_LOW_WRITE;
    end else if (ce) begin
      cable_r     <= cable_nxt;
      cable_low_r <= cable_low_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Event mask and edge detection
  // --------------------------------------------------------------------
  logic [15:0] mask_r;
  logic [15:0] mask_nxt;
  logic        link_d_r;
  logic        energy_d_r;
  logic [15:0] detect;
  assign mask_nxt = wr_mask ? (req.wdata & EV_IMPL_MASK) : mask_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mask_r     <= MASK_RESET;
      link_d_r   <= 1'b0;
      energy_d_r <= 1'b0;
    end else if (ce) begin
      mask_r     <= mask_nxt;
      link_d_r   <= phy_stat.link_up;
      energy_d_r <= phy_stat.energy_on;
    end
  end

  always_comb begin
    detect               = 16'h0000;
    detect[EV_LINK_UP]   = phy_stat.link_up & ~link_d_r;
    detect[EV_WAKE]      = phy_stat.wake;
    detect[EV_ENERGY]    = phy_stat.energy_on & ~energy_d_r;
    detect[EV_NEG_DONE]  = phy_stat.neg_done;
    detect[EV_REM_FAULT] = phy_stat.remote_fault;
    detect[EV_LINK_DOWN] = ~phy_stat.link_up & link_d_r;
    detect[EV_PART_ACK]  = phy_stat.partner_ack;
    detect[EV_PD_FAULT]  = phy_stat.pd_fault;
    detect[EV_PAGE_RX]   = phy_stat.page_rx;
  end

  event_flag_bank u_flags (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .ce          (ce),
    .detect      (detect),
    .enable_mask (mask_r),
    .clear_rd    (rd_flags),
    .flags       (event_flags)
  );

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  logic [15:0] rd_mux;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  always_comb begin
    case (req.addr)
      IDX_MODE_CTRL_STAT: rd_mux = {xo_override, xo_auto, xo_state, 11'h000,
                                    phy_stat.energy_on, 1'b0};
      IDX_CABLE_LEN:      rd_mux = {cable_r, cable_low_r};
      IDX_EVENT_FLAGS:    rd_mux = event_flags;
      IDX_EVENT_MASK:     rd_mux = mask_r;
      default:            rd_mux = 16'h0000;
    endcase
  end
  assign rdata_nxt = req.rd ? rd_mux : 16'h0000;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_r <= 16'h0000;
    end else if (ce) begin
      rdata_r <= rdata_nxt;
    end
  end
  assign rdata = rdata_r;

endmodule
`default_nettype wire

// ===== rtl/phy_mgmt_pkg.sv
// Package for the per-port PHY management register bank.
// Assumes a 16-bit register port addressed by register index.
package phy_mgmt_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // Register indices.
  localparam logic [4:0] IDX_MODE_CTRL_STAT = 5'h11;
  localparam logic [4:0] IDX_CABLE_LEN      = 5'h1c;
  localparam logic [4:0] IDX_EVENT_FLAGS    = 5'h1d;
  localparam logic [4:0] IDX_EVENT_MASK     = 5'h1e;
  localparam logic [4:0] IDX_LINK_STATUS    = 5'h10;

  // Field positions in the crossover control register.
  localparam int XO_OVERRIDE_BIT = 15;
  localparam int XO_AUTO_BIT     = 14;
  localparam int XO_STATE_BIT    = 13;
  localparam int ENERGY_BIT      = 1;

  // Cable length field.
  localparam int CBL_MSB = 15;
  localparam int CBL_LSB = 12;
  localparam logic [3:0]  CBL_RESET     = 4'h0;
  localparam logic [11:0] CBL_LOW_WRITE = 12'h800;

  // Event flag positions.
  localparam int EV_PAGE_RX   = 1;
  localparam int EV_PD_FAULT  = 2;
  localparam int EV_PART_ACK  = 3;
  localparam int EV_LINK_DOWN = 4;
  localparam int EV_REM_FAULT = 5;
  localparam int EV_NEG_DONE  = 6;
  localparam int EV_ENERGY    = 7;
  localparam int EV_WAKE      = 8;
  localparam int EV_LINK_UP   = 9;
  localparam logic [15:0] EV_IMPL_MASK  = 16'h03fe;
  localparam logic [15:0] EV_RESET      = 16'h0000;
  localparam logic [15:0] MASK_RESET    = 16'h0000;
  localparam logic [2:0]  CTRL_RESET    = 3'h0;

  // Effective crossover mode.
  typedef enum logic [1:0] {
    XO_STRAIGHT,
    XO_CROSS,
    XO_AUTO
  } xover_mode_t;

  // Register port request.
  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // Raw PHY status and event inputs.
  typedef struct packed {
    logic link_up;
    logic energy_on;
    logic wake;
    logic neg_done;
    logic remote_fault;
    logic partner_ack;
    logic pd_fault;
    logic page_rx;
    logic speed_100;
    logic cable_fault;
    logic [3:0] cable_len;
  } phy_status_t;

endpackage

// ===== rtl/event_flag_bank.sv
// Latched event flags, cleared by a read, gated by an enable mask.
// Assumes detect pulses and the clearing read are synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module event_flag_bank (
  // Clock and control
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Events and control
  input  wire logic [15:0] detect,
  input  wire logic [15:0] enable_mask,
  input  wire logic        clear_rd,
  // Flags
  output logic      [15:0] flags
);
  import phy_mgmt_pkg::*;

  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_flag
      if (EV_IMPL_MASK[i]) begin : g_impl
        logic flag_r;
        logic set;
        logic flag_nxt;
        assign set      = detect[i] & enable_mask[i];
        assign flag_nxt = set | (flag_r & ~clear_rd);
        always_ff @(posedge mclk) begin
          if (!rst_n) begin
            flag_r <= EV_RESET[i];
          end else if (ce) begin
            flag_r <= flag_nxt;
          end
        end
        assign flags[i] = flag_r;
      end else begin : g_rsvd
        assign flags[i] = 1'b0;
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== bench/phy_regs_properties.sv
// Port checker for the PHY register bank.
// Assumes ce stays high while registers are accessed.
`timescale 1ns/1ps
`default_nettype none
module phy_regs_properties (
  // Watched ports
  input wire logic                      mclk,
  input wire logic                      rst_n,
  input wire logic                      ce,
  input wire phy_mgmt_pkg::reg_req_t    req,
  input wire logic               [15:0] rdata,
  input wire logic                      auto_xover_strap,
  input wire logic                      manual_xover_strap,
  input wire phy_mgmt_pkg::phy_status_t phy_stat,
  input wire phy_mgmt_pkg::xover_mode_t xover_mode,
  input wire logic               [15:0] event_flags
);
  import phy_mgmt_pkg::*;
  logic [2:0]  ctl_r;
  logic        link_r;
  logic        nrg_r;
  logic [15:0] ev;
  xover_mode_t sm;
  xover_mode_t rm;
  wire rd_fl = ce && req.rd && req.addr == IDX_EVENT_FLAGS;
  wire rd_cb = ce && req.rd && req.addr == IDX_CABLE_LEN;
  assign ev = {6'h00, phy_stat.link_up & ~link_r, phy_stat.wake, phy_stat.energy_on & ~nrg_r,
               phy_stat.neg_done, phy_stat.remote_fault, ~phy_stat.link_up & link_r,
               phy_stat.partner_ack, phy_stat.pd_fault, phy_stat.page_rx, 1'b0};
  assign sm = auto_xover_strap ? XO_AUTO : (manual_xover_strap ? XO_CROSS : XO_STRAIGHT);
  assign rm = ctl_r[1] ? XO_AUTO : (ctl_r[0] ? XO_CROSS : XO_STRAIGHT);
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctl_r <= 3'h0;
      link_r <= 1'b0;
      nrg_r <= 1'b0;
    end else if (ce) begin
      link_r <= phy_stat.link_up;
      nrg_r <= phy_stat.energy_on;
      if (req.wr && req.addr == IDX_MODE_CTRL_STAT) ctl_r <= req.wdata[15:13];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_hold; ce && !rd_fl |=> (event_flags & $past(event_flags)) == $past(event_flags);
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_new; ce |=> (event_flags & ~$past(event_flags) & ~$past(ev)) == 16'h0000;
  endproperty
  a_new: assert property (p_new) else $error("flag without event");
  property p_unused; (event_flags & ~EV_IMPL_MASK) == 16'h0000; endproperty
  a_unused: assert property (p_unused) else $error("unused flag set");
  property p_ret; rd_fl |=> rdata == $past(event_flags); endproperty
  a_ret: assert property (p_ret) else $error("read data wrong");
  property p_clr; rd_fl |=> (event_flags & ~$past(ev)) == 16'h0000; endproperty
  a_clr: assert property (p_clr) else $error("flags not cleared");
  property p_len; rd_cb && $past(rst_n) && $past(phy_stat.link_up & phy_stat.speed_100 &
    ~phy_stat.cable_fault) |=> rdata[15:12] == $past(phy_stat.cable_len, 2); endproperty
  a_len: assert property (p_len) else $error("length wrong");
  property p_slow; rd_cb && !$past(phy_stat.speed_100) |=> rdata[15:12] == 4'h0; endproperty
  a_slow: assert property (p_slow) else $error("length at low speed");
  property p_strap; ce && !ctl_r[2] |=> xover_mode == $past(sm); endproperty
  a_strap: assert property (p_strap) else $error("strap mode wrong");
  property p_ovr; ce && ctl_r[2] |=> xover_mode == $past(rm); endproperty
  a_ovr: assert property (p_ovr) else $error("register mode wrong");
endmodule
bind phy_crossover_cable_irq_regs phy_regs_properties u_props (.mclk(mclk), .rst_n(rst_n),
  .ce(ce), .req(req), .rdata(rdata), .auto_xover_strap(auto_xover_strap),
  .manual_xover_strap(manual_xover_strap), .phy_stat(phy_stat), .xover_mode(xover_mode),
  .event_flags(event_flags));
`default_nettype wire

// ===== bench/host_model.sv
// Host software model issuing register writes and reads.
// Assumes read data stand one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Register port
  input  wire logic                   mclk,
  output phy_mgmt_pkg::reg_req_t      req,
  input  wire logic            [15:0] rdata
);
  import phy_mgmt_pkg::*;
  initial req = '0;
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] v;
    v = d;
    if (a == IDX_CABLE_LEN) v[11:0] = CBL_LOW_WRITE;
    if (a == IDX_MODE_CTRL_STAT && v[14]) v[13] = 1'b0;
    @(posedge mclk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    // Read data stand only in this cycle; take them mid-cycle where they are settled.
    @(negedge mclk);
    d = rdata;
    @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// ===== bench/phy_crossover_cable_irq_regs_tb.sv
// Testbench for the PHY register bank.
// Assumes the host model owns the register port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module phy_crossover_cable_irq_regs_tb;
  import phy_mgmt_pkg::*;
  logic        mclk, rst_n, ce, sa, sm;
  reg_req_t    req;
  logic [15:0] rdata, fl, d;
  phy_status_t ps;
  xover_mode_t mode;
  int          fails, compares;
  phy_crossover_cable_irq_regs u_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .req(req),
    .rdata(rdata), .auto_xover_strap(sa), .manual_xover_strap(sm), .phy_stat(ps),
    .xover_mode(mode), .event_flags(fl));
  host_model u_host (.mclk(mclk), .req(req), .rdata(rdata));
  function automatic xover_mode_t exp_mode(input int i);
    return i[1] ? XO_AUTO : (i[0] ? XO_CROSS : XO_STRAIGHT);
  endfunction
  task automatic close_out;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic fire(input int b);
    @(posedge mclk);
    case (b)
      9: ps.link_up <= 1'b1;
      8: ps.wake <= 1'b1;
      7: ps.energy_on <= 1'b1;
      6: ps.neg_done <= 1'b1;
      5: ps.remote_fault <= 1'b1;
      4: ps.link_up <= 1'b0;
      3: ps.partner_ack <= 1'b1;
      2: ps.pd_fault <= 1'b1;
      default: ps.page_rx <= 1'b1;
    endcase
    @(posedge mclk);
    {ps.wake, ps.neg_done, ps.remote_fault, ps.partner_ack, ps.pd_fault, ps.page_rx} <= 6'h00;
    ps.energy_on <= 1'b0;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    #200000;
    fails++;
    close_out();
  end
  initial begin
    {rst_n, sa, sm} = 3'h0;
    ce = 1'b1;
    ps = '0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    u_host.rd(IDX_CABLE_LEN, d);
    `CHK(d, 16'h0800)
    for (int b = 9; b > 0; b--) fire(b);
    u_host.rd(IDX_EVENT_FLAGS, d);
    `CHK(d, 16'h0000)
    u_host.wr(IDX_EVENT_MASK, 16'h03fe);
    for (int b = 9; b > 0; b--) begin
      fire(b);
      u_host.rd(IDX_EVENT_FLAGS, d);
      `CHK(d, 16'h0001 << b)
    end
    u_host.wr(IDX_EVENT_MASK, 16'h0040);
    fire(5);
    fork
      u_host.rd(IDX_EVENT_FLAGS, d);
      fire(6);
    join
    `CHK(d, 16'h0000)
    u_host.rd(IDX_EVENT_FLAGS, d);
    `CHK(d, 16'h0040)
    u_host.rd(IDX_EVENT_FLAGS, d);
    `CHK(d, 16'h0000)
    {ps.link_up, ps.speed_100, ps.cable_len} <= 6'h3a;
    u_host.wr(IDX_CABLE_LEN, 16'h5000);
    u_host.rd(IDX_CABLE_LEN, d);
    `CHK(d, 16'ha800)
    ps.cable_fault <= 1'b1;
    u_host.rd(IDX_CABLE_LEN, d);
    `CHK(d, 16'h0800)
    {ps.speed_100, ps.cable_fault} <= 2'h0;
    u_host.rd(IDX_CABLE_LEN, d);
    `CHK(d, 16'h0800)
    for (int i = 0; i < 4; i++) begin
      {sa, sm} <= i[1:0];
      repeat (3) @(posedge mclk);
      `CHK(mode, exp_mode(i))
    end
    for (int i = 0; i < 3; i++) begin
      u_host.wr(IDX_MODE_CTRL_STAT, {1'b1, i[1:0], 13'h0000});
      repeat (3) @(posedge mclk);
      `CHK(mode, exp_mode(i))
    end
    u_host.wr(IDX_MODE_CTRL_STAT, 16'h0000);
    repeat (3) @(posedge mclk);
    `CHK(mode, XO_AUTO)
    close_out();
  end
endmodule
`default_nettype wire
